//--- imu_abf_config.sv
`default_nettype none
// Notes on behaviour
// - x bias low 0x4C, high 0x4E, added
// - y bias low 0x50, high 0x52, added
// - z bias low 0x54, high 0x56, added
// - bias words are two's complement accel format
// - filter exponent bits 2:0 at 0x5C
// - two cascaded averaging stages, triangular response
// - misc bit 7 enables linear-g compensation
// - misc bit 6 enables percussion alignment
// - misc bits 4:2 select timing mode
// - misc bit 1 picks sync pin edge
// - misc bit 0 sets data ready polarity
// - misc resets to 0x00C1
// - alignment refers accels to corner A1
// - bias follows factory stage, 2 kHz internal
// - output mode pulses sync pin per sample
// - direct mode: gyro on the misc bit 1 edge, accel both edges
module imu_abf_config #(
	parameter int unsigned HALF_CYC = imu_abf_pkg::ACCEL_HALF_CYC
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic spi_sclk,
	input wire logic spi_cs_b,
	input wire logic spi_din,
	output logic spi_dout,
	output logic data_ready_pin,
	input wire logic sync_pin_in,
	output logic sync_pin_out,
	output logic sync_pin_oe,
	input wire logic accel_raw_valid,
	input wire imu_abf_pkg::imu_abf_accel_t accel_raw,
	output logic accel_sample_req,
	output logic gyro_sample_req,
	output logic lin_g_comp_en,
	output logic pop_align_en,
	output logic accel_out_valid,
	output imu_abf_pkg::imu_abf_accel_t accel_out
);
	typedef enum {
		SPI_IDLE,
		SPI_SHIFT
	} imu_abf_spi_state_t;

	typedef struct packed {
		logic [5:0][15:0] bias;
		logic [2:0] fir_b;
		logic [15:0] misc;
	} imu_abf_regs_t;

	typedef struct packed {
		logic sclk_m;
		logic sclk_s;
		logic sclk_p;
		logic cs_m;
		logic cs_s;
		logic cs_p;
		logic din_m;
		logic din_s;
		imu_abf_spi_state_t spi_st;
		logic [4:0] bit_cnt;
		logic [15:0] rx;
		logic [15:0] tx;
		logic [15:0] resp;
		logic dout;
		imu_abf_regs_t regs;
		logic have_first;
		imu_abf_pkg::imu_abf_accel_t first;
		logic st1_valid;
		imu_abf_pkg::imu_abf_accel_t st1_data;
		logic dr_active;
		logic dr_pin;
	} imu_abf_cfg_t;

	imu_abf_cfg_t c_r;
	imu_abf_cfg_t c_nxt;

	logic st1_out_valid;
	imu_abf_pkg::imu_abf_accel_t st1_out;
	logic st2_out_valid;
	imu_abf_pkg::imu_abf_accel_t st2_out;
	logic [2:0] mode;

	assign mode = c_r.regs.misc[imu_abf_pkg::MISC_MODE_MSB:
		imu_abf_pkg::MISC_MODE_LSB];

	function automatic logic [15:0] read_reg(input imu_abf_regs_t r,
		input logic [6:0] addr);
		logic [6:0] wa;
		logic [15:0] v;
		wa = {addr[6:1], 1'b0};
		v = 16'h0000;
		case (wa)
			imu_abf_pkg::ADDR_ACC_X_LO: v = r.bias[0];
			imu_abf_pkg::ADDR_ACC_X_HI: v = r.bias[1];
			imu_abf_pkg::ADDR_ACC_Y_LO: v = r.bias[2];
			imu_abf_pkg::ADDR_ACC_Y_HI: v = r.bias[3];
			imu_abf_pkg::ADDR_ACC_Z_LO: v = r.bias[4];
			imu_abf_pkg::ADDR_ACC_Z_HI: v = r.bias[5];
			imu_abf_pkg::ADDR_FIR: v = {13'h0000, r.fir_b};
			imu_abf_pkg::ADDR_MISC:
				v = r.misc & imu_abf_pkg::MISC_RD_MASK;
			default: v = 16'h0000;
		endcase
		return v;
	endfunction

	// even address takes the low byte, odd the high byte
	function automatic imu_abf_regs_t write_byte(input imu_abf_regs_t r,
		input logic [6:0] addr, input logic [7:0] d);
		imu_abf_regs_t n;
		logic [6:0] wa;
		logic [15:0] w;
		n = r;
		wa = {addr[6:1], 1'b0};
		w = read_reg(r, addr);
		if (addr[0]) begin
			w[15:8] = d;
		end else begin
			w[7:0] = d;
		end
		case (wa)
			imu_abf_pkg::ADDR_ACC_X_LO: n.bias[0] = w;
			imu_abf_pkg::ADDR_ACC_X_HI: n.bias[1] = w;
			imu_abf_pkg::ADDR_ACC_Y_LO: n.bias[2] = w;
			imu_abf_pkg::ADDR_ACC_Y_HI: n.bias[3] = w;
			imu_abf_pkg::ADDR_ACC_Z_LO: n.bias[4] = w;
			imu_abf_pkg::ADDR_ACC_Z_HI: n.bias[5] = w;
			imu_abf_pkg::ADDR_FIR:
				n.fir_b = w[imu_abf_pkg::FIR_B_MSB:0];
			imu_abf_pkg::ADDR_MISC:
				n.misc = w & imu_abf_pkg::MISC_RD_MASK;
			default: n = r;
		endcase
		return n;
	endfunction

	always_comb begin
		logic sclk_rise;
		logic sclk_fall;
		logic cs_fall;
		logic [15:0] frame;
		logic [6:0] addr;
		logic pair;
		logic [32:0] avg;
		imu_abf_pkg::imu_abf_accel_t a;
		sclk_rise = c_r.sclk_s & ~c_r.sclk_p;
		sclk_fall = ~c_r.sclk_s & c_r.sclk_p;
		cs_fall = ~c_r.cs_s & c_r.cs_p;
		frame = {c_r.rx[14:0], c_r.din_s};
		addr = frame[imu_abf_pkg::FRAME_ADDR_MSB:
			imu_abf_pkg::FRAME_ADDR_LSB];
		avg = '0;
		a = '0;
		c_nxt = c_r;
		c_nxt.sclk_m = spi_sclk;
		c_nxt.sclk_s = c_r.sclk_m;
		c_nxt.sclk_p = c_r.sclk_s;
		c_nxt.cs_m = spi_cs_b;
		c_nxt.cs_s = c_r.cs_m;
		c_nxt.cs_p = c_r.cs_s;
		c_nxt.din_m = spi_din;
		c_nxt.din_s = c_r.din_m;
		c_nxt.st1_valid = 1'b0;

		// serial slave, sample on rising, shift out on falling
		case (c_r.spi_st)
			SPI_IDLE: begin
				if (cs_fall) begin
					c_nxt.spi_st = SPI_SHIFT;
					c_nxt.bit_cnt = '0;
					c_nxt.tx = c_r.resp;
				end
			end
			SPI_SHIFT: begin
				if (c_r.cs_s) begin
					c_nxt.spi_st = SPI_IDLE;
				end else if (sclk_rise) begin
					c_nxt.rx = frame;
					c_nxt.bit_cnt = c_r.bit_cnt + 5'h01;
					if (c_r.bit_cnt == 5'(imu_abf_pkg::FRAME_BITS - 1)) begin
						c_nxt.bit_cnt = '0;
						if (frame[imu_abf_pkg::FRAME_WR_BIT]) begin
							c_nxt.regs = write_byte(c_r.regs, addr,
								frame[7:0]);
						end else begin
							c_nxt.resp = read_reg(c_r.regs, addr);
						end
						c_nxt.tx = c_nxt.resp;
					end
				end else if (sclk_fall) begin
					c_nxt.dout = c_r.tx[15];
					c_nxt.tx = {c_r.tx[14:0], 1'b0};
				end
			end
			default: c_nxt.spi_st = SPI_IDLE;
		endcase

		// pair averaging, then user bias after factory stage
		pair = (mode != imu_abf_pkg::MODE_PULSE)
			&& (mode != imu_abf_pkg::MODE_SCALED);
		if (accel_raw_valid) begin
			if (pair && !c_r.have_first) begin
				c_nxt.have_first = 1'b1;
				c_nxt.first = accel_raw;
			end else begin
				c_nxt.have_first = 1'b0;
				for (int i = 0; i < 3; i++) begin
					if (pair) begin
						avg = 33'($signed(c_r.first.axis[i]))
							+ 33'($signed(accel_raw.axis[i]));
						a.axis[i] = avg[32:1];
					end else begin
						a.axis[i] = accel_raw.axis[i];
					end
					c_nxt.st1_data.axis[i] = a.axis[i]
						+ {c_r.regs.bias[2*i+1], c_r.regs.bias[2*i]};
				end
				c_nxt.st1_valid = 1'b1;
			end
		end

		// data ready: set on new output, cleared when a frame starts
		if (st2_out_valid) begin
			c_nxt.dr_active = 1'b1;
		end else if (cs_fall) begin
			c_nxt.dr_active = 1'b0;
		end
		c_nxt.dr_pin = c_r.regs.misc[imu_abf_pkg::MISC_DR_POL_BIT]
			? c_nxt.dr_active : ~c_nxt.dr_active;
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			c_r <= '0;
			c_r.sclk_m <= 1'b1;
			c_r.sclk_s <= 1'b1;
			c_r.sclk_p <= 1'b1;
			c_r.cs_m <= 1'b1;
			c_r.cs_s <= 1'b1;
			c_r.cs_p <= 1'b1;
			c_r.spi_st <= SPI_IDLE;
			c_r.regs.bias <= {6{imu_abf_pkg::RST_BIAS}};
			c_r.regs.fir_b <= imu_abf_pkg::RST_FIR_B;
			c_r.regs.misc <= imu_abf_pkg::RST_MISC;
		end else begin
			c_r <= c_nxt;
		end
	end

	// two identical boxcars in cascade give the triangular window
	imu_abf_avg_stage u_stage1 (
		.clock(clock),
		.rst_b(rst_b),
		.size_b(c_r.regs.fir_b),
		.in_valid(c_r.st1_valid),
		.in_data(c_r.st1_data),
		.out_valid(st1_out_valid),
		.out_data(st1_out)
	);

	imu_abf_avg_stage u_stage2 (
		.clock(clock),
		.rst_b(rst_b),
		.size_b(c_r.regs.fir_b),
		.in_valid(st1_out_valid),
		.in_data(st1_out),
		.out_valid(st2_out_valid),
		.out_data(st2_out)
	);

	imu_abf_sample_timer #(
		.HALF_CYC(HALF_CYC)
	) u_timer (
		.clock(clock),
		.rst_b(rst_b),
		.sync_pin_in(sync_pin_in),
		.mode(mode),
		.sync_rising(c_r.regs.misc[imu_abf_pkg::MISC_SYNC_POL_BIT]),
		.accel_tick(accel_sample_req),
		.gyro_tick(gyro_sample_req),
		.sync_pin_out(sync_pin_out),
		.sync_pin_oe(sync_pin_oe)
	);

	assign spi_dout = c_r.dout;
	assign data_ready_pin = c_r.dr_pin;
	assign lin_g_comp_en = c_r.regs.misc[imu_abf_pkg::MISC_LING_BIT];
	// realised by factory stage under this enable
	assign pop_align_en = c_r.regs.misc[imu_abf_pkg::MISC_POP_BIT];
	assign accel_out_valid = st2_out_valid;
	assign accel_out = st2_out;
endmodule // imu_abf_config
`default_nettype wire

//--- imu_abf_pkg.sv
`default_nettype none
package imu_abf_pkg;

	// timing
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned SAMPLE_HZ = 2000;
	localparam int unsigned ACCEL_HZ = 2 * SAMPLE_HZ;
	localparam int unsigned ACCEL_HALF_CYC = CLK_HZ / ACCEL_HZ;
	localparam int unsigned SYNC_PULSE_NS = 1000;
	localparam int unsigned SYNC_PULSE_CYC =
		(SYNC_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

	// serial frame layout
	localparam int unsigned FRAME_BITS = 16;
	localparam int unsigned FRAME_WR_BIT = 15;
	localparam int unsigned FRAME_ADDR_MSB = 14;
	localparam int unsigned FRAME_ADDR_LSB = 8;

	// byte addresses of the register map
	localparam logic [6:0] ADDR_ACC_X_LO = 7'h4C;
	localparam logic [6:0] ADDR_ACC_X_HI = 7'h4E;
	localparam logic [6:0] ADDR_ACC_Y_LO = 7'h50;
	localparam logic [6:0] ADDR_ACC_Y_HI = 7'h52;
	localparam logic [6:0] ADDR_ACC_Z_LO = 7'h54;
	localparam logic [6:0] ADDR_ACC_Z_HI = 7'h56;
	localparam logic [6:0] ADDR_FIR = 7'h5C;
	localparam logic [6:0] ADDR_MISC = 7'h60;

	// reset values
	localparam logic [15:0] RST_BIAS = 16'h0000;
	localparam logic [2:0] RST_FIR_B = 3'h0;
	localparam logic [15:0] RST_MISC = 16'h00C1;

	// field positions
	localparam int unsigned FIR_B_MSB = 2;
	localparam int unsigned MISC_LING_BIT = 7;
	localparam int unsigned MISC_POP_BIT = 6;
	localparam int unsigned MISC_MODE_MSB = 4;
	localparam int unsigned MISC_MODE_LSB = 2;
	localparam int unsigned MISC_SYNC_POL_BIT = 1;
	localparam int unsigned MISC_DR_POL_BIT = 0;
	localparam logic [15:0] MISC_RD_MASK = 16'h00DF;

	// timing mode codes
	localparam logic [2:0] MODE_INTERNAL = 3'h0;
	localparam logic [2:0] MODE_DIRECT = 3'h1;
	localparam logic [2:0] MODE_SCALED = 3'h2;
	localparam logic [2:0] MODE_OUTPUT = 3'h3;
	localparam logic [2:0] MODE_PULSE = 3'h5;

	localparam int unsigned ACC_W = 32;
	localparam int unsigned FIR_BMAX = 7;

	typedef struct packed {
		logic [2:0][ACC_W-1:0] axis;
	} imu_abf_accel_t;

endpackage
`default_nettype wire

//--- imu_abf_avg_stage.sv
`default_nettype none
module imu_abf_avg_stage #(
	parameter int BMAX = imu_abf_pkg::FIR_BMAX
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [2:0] size_b,
	input wire logic in_valid,
	input wire imu_abf_pkg::imu_abf_accel_t in_data,
	output logic out_valid,
	output imu_abf_pkg::imu_abf_accel_t out_data
);
	localparam int DEPTH = 1 << BMAX;
	localparam int SW = imu_abf_pkg::ACC_W + BMAX;

	typedef struct packed {
		imu_abf_pkg::imu_abf_accel_t [DEPTH-1:0] hist;
		logic [BMAX-1:0] wp;
		logic [2:0][SW-1:0] sum;
		logic [2:0] size_last;
		logic out_valid;
		imu_abf_pkg::imu_abf_accel_t out_data;
	} imu_abf_stage_t;

	imu_abf_stage_t s_r;
	imu_abf_stage_t s_nxt;

	always_comb begin
		imu_abf_pkg::imu_abf_accel_t old;
		logic signed [SW-1:0] acc;
		logic [BMAX-1:0] back;
		old = '0;
		acc = '0;
		back = BMAX'(1) << size_b;
		s_nxt = s_r;
		s_nxt.out_valid = 1'b0;
		// a full-depth window wraps back to the slot being written
		old = s_r.hist[s_r.wp - back];
		if (size_b != s_r.size_last) begin
			// new window length: flush history
			s_nxt.hist = '0;
			s_nxt.sum = '0;
			s_nxt.wp = '0;
			s_nxt.size_last = size_b;
		end else if (in_valid) begin
			// sliding 2^B tap boxcar
			for (int i = 0; i < 3; i++) begin
				acc = $signed(s_r.sum[i])
					+ SW'($signed(in_data.axis[i]))
					- SW'($signed(old.axis[i]));
				s_nxt.sum[i] = acc;
				acc = acc >>> size_b;
				s_nxt.out_data.axis[i] = acc[imu_abf_pkg::ACC_W-1:0];
			end
			s_nxt.hist[s_r.wp] = in_data;
			s_nxt.wp = s_r.wp + BMAX'(1);
			s_nxt.out_valid = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign out_valid = s_r.out_valid;
	assign out_data = s_r.out_data;
endmodule // imu_abf_avg_stage
`default_nettype wire

//--- imu_abf_sample_timer.sv
`default_nettype none
module imu_abf_sample_timer #(
	parameter int unsigned HALF_CYC = imu_abf_pkg::ACCEL_HALF_CYC
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic sync_pin_in,
	input wire logic [2:0] mode,
	input wire logic sync_rising,
	output logic accel_tick,
	output logic gyro_tick,
	output logic sync_pin_out,
	output logic sync_pin_oe
);
	localparam int CW = $clog2(HALF_CYC + 1);
	localparam int PW = $clog2(imu_abf_pkg::SYNC_PULSE_CYC + 1);

	typedef struct packed {
		logic sy_m;
		logic sy_s;
		logic sy_p;
		logic [CW-1:0] cnt;
		logic phase;
		logic [PW-1:0] pulse;
		logic accel_tick;
		logic gyro_tick;
		logic sync_out;
		logic sync_oe;
	} imu_abf_timer_t;

	imu_abf_timer_t t_r;
	imu_abf_timer_t t_nxt;

	always_comb begin
		logic rise;
		logic fall;
		logic act;
		logic pas;
		logic own_clk;
		rise = t_r.sy_s & ~t_r.sy_p;
		fall = ~t_r.sy_s & t_r.sy_p;
		act = sync_rising ? rise : fall;
		pas = sync_rising ? fall : rise;
		own_clk = (mode == imu_abf_pkg::MODE_INTERNAL)
			|| (mode == imu_abf_pkg::MODE_OUTPUT);
		t_nxt = t_r;
		t_nxt.sy_m = sync_pin_in;
		t_nxt.sy_s = t_r.sy_m;
		t_nxt.sy_p = t_r.sy_s;
		t_nxt.accel_tick = 1'b0;
		t_nxt.gyro_tick = 1'b0;
		t_nxt.cnt = '0;
		if (own_clk) begin
			// 4 kHz accel ticks, every second one is a 2 kHz cycle
			if (t_r.cnt == CW'(HALF_CYC - 1)) begin
				t_nxt.accel_tick = 1'b1;
				t_nxt.phase = ~t_r.phase;
				t_nxt.gyro_tick = t_r.phase;
			end else begin
				t_nxt.cnt = t_r.cnt + CW'(1);
			end
		end else if (mode == imu_abf_pkg::MODE_DIRECT) begin
			t_nxt.gyro_tick = act;
			t_nxt.accel_tick = act | pas;
		end else begin
			t_nxt.gyro_tick = act;
			t_nxt.accel_tick = act;
		end
		// output mode: pulse the pin per data collection
		if (t_r.pulse != '0) begin
			t_nxt.pulse = t_r.pulse - PW'(1);
		end
		if (mode == imu_abf_pkg::MODE_OUTPUT && t_nxt.gyro_tick) begin
			t_nxt.pulse = PW'(imu_abf_pkg::SYNC_PULSE_CYC);
		end
		t_nxt.sync_oe = (mode == imu_abf_pkg::MODE_OUTPUT);
		t_nxt.sync_out = (t_nxt.pulse != '0) ? sync_rising
			: ~sync_rising;
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			t_r <= '0;
		end else begin
			t_r <= t_nxt;
		end
	end

	assign accel_tick = t_r.accel_tick;
	assign gyro_tick = t_r.gyro_tick;
	assign sync_pin_out = t_r.sync_out;
	assign sync_pin_oe = t_r.sync_oe;
endmodule // imu_abf_sample_timer
`default_nettype wire

//--- imu_abf_host.sv
`default_nettype none
module imu_abf_host (
	input wire logic clock,
	output logic sclk,
	output logic cs_b,
	output logic din,
	input wire logic dout
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		sclk = 1'b1;
		cs_b = 1'b1;
		din = 1'b0;
	end
	// mode 3, msb first; frames start just after a clock edge
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		@(posedge clock);
		#2 cs_b = 1'b0;
		#81;
		for (int i = 15; i >= 0; i--) begin
			sclk = 1'b0;
			din = tx[i];
			#79;
			sclk = 1'b1;
			rx[i] = dout;
			#81;
		end
		cs_b = 1'b1;
		din = ~din;
		#100;
	endtask
endmodule // imu_abf_host
`default_nettype wire

//--- imu_abf_chk.sv
`default_nettype none
module imu_abf_chk (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic spi_sclk,
	input wire logic spi_cs_b,
	input wire logic spi_dout,
	input wire logic sync_pin_out,
	input wire logic sync_pin_oe,
	input wire logic accel_sample_req,
	input wire logic gyro_sample_req,
	input wire logic lin_g_comp_en,
	input wire logic pop_align_en,
	input wire logic accel_out_valid,
	input wire imu_abf_pkg::imu_abf_accel_t accel_out
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	sequence s_no_acc;
		!accel_sample_req [*8];
	endsequence
	sequence s_still;
		$stable(sync_pin_out) [*8];
	endsequence
	property p_dflt;
		$rose(rst_b) |-> lin_g_comp_en && pop_align_en && !sync_pin_oe;
	endproperty
	property p_gap;
		accel_sample_req |=> s_no_acc;
	endproperty
	property p_pair;
		gyro_sample_req |-> accel_sample_req;
	endproperty
	property p_hold;
		!accel_out_valid |-> $stable(accel_out);
	endproperty
	property p_width;
		sync_pin_oe && $changed(sync_pin_out) |=> s_still;
	endproperty
	property p_start;
		sync_pin_oe && gyro_sample_req |-> ##[0:1] $changed(sync_pin_out);
	endproperty
	property p_lin;
		$changed(lin_g_comp_en) |-> !$past(spi_cs_b, 2);
	endproperty
	property p_pop;
		$changed(pop_align_en) |-> !$past(spi_cs_b, 2);
	endproperty
	property p_dout;
		$changed(spi_dout) |-> !$past(spi_sclk);
	endproperty
	a_dflt: assert property (p_dflt) else $error("bad reset state");
	a_gap: assert property (p_gap) else $error("sample too soon");
	a_pair: assert property (p_pair) else $error("lone gyro req");
	a_hold: assert property (p_hold) else $error("output moved");
	a_width: assert property (p_width) else $error("sync short");
	a_start: assert property (p_start) else $error("no sync pulse");
	a_lin: assert property (p_lin) else $error("lin_g moved");
	a_pop: assert property (p_pop) else $error("pop moved");
	a_dout: assert property (p_dout) else $error("dout early");
endmodule // imu_abf_chk
`default_nettype wire

//--- imu_abf_config_tb.sv
`default_nettype none
module imu_abf_config_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int unsigned HC = 40;
	logic clock, rst_b, sclk, cs_b, din, dout, dr, s_out, s_oe, tb_sync;
	logic raw_v, a_req, g_req, lin, pop, out_v, exp_dr;
	imu_abf_pkg::imu_abf_accel_t raw, acc_out, e_m, exp_q[$];
	int errors = 0, check_count = 0, na = 0, ng = 0;
	logic [31:0] bias [3];
	longint h1 [3][8], h2 [3][8];
	logic [2:0] fb;
	logic [6:0] ra [8] = '{7'h4C, 7'h4E, 7'h50, 7'h52, 7'h54, 7'h56,
		7'h5C, 7'h60};
	logic [2:0] mt [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};
	logic pt [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
	int at [5] = '{8, 7, 3, 8, 3};
	int gt [5] = '{4, 3, 3, 4, 3};
	wire logic sync_w = s_oe ? s_out : tb_sync;
	imu_abf_config #(.HALF_CYC(HC)) DUT (
		.clock, .rst_b, .spi_sclk(sclk), .spi_cs_b(cs_b), .spi_din(din),
		.spi_dout(dout), .data_ready_pin(dr), .sync_pin_in(sync_w),
		.sync_pin_out(s_out), .sync_pin_oe(s_oe), .accel_raw_valid(raw_v),
		.accel_raw(raw), .accel_sample_req(a_req), .gyro_sample_req(g_req),
		.lin_g_comp_en(lin), .pop_align_en(pop), .accel_out_valid(out_v),
		.accel_out(acc_out)
	);
	imu_abf_host u_host (.clock, .sclk, .cs_b, .din, .dout);
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [15:0] rx;
		u_host.xfer({1'b1, a, d}, rx);
	endtask
	task automatic wr16(input logic [6:0] a, input logic [15:0] d);
		wr(a, d[7:0]);
		wr(a | 7'h01, d[15:8]);
	endtask
	task automatic rdchk(input logic [6:0] a, input logic [15:0] e);
		logic [15:0] d;
		u_host.xfer({1'b0, a, 8'h00}, d);
		u_host.xfer(16'h0000, d);
		chk(d, e);
	endtask
	function automatic longint sx(input logic [31:0] v);
		return longint'($signed(v));
	endfunction
	// two cascaded boxcars of 2**fb taps
	function automatic logic [31:0] model(input int ax, input longint x);
		longint s1 = 0;
		longint s2 = 0;
		for (int k = 7; k > 0; k--) begin
			h1[ax][k] = h1[ax][k-1];
			h2[ax][k] = h2[ax][k-1];
		end
		h1[ax][0] = x;
		for (int k = 0; k < (1 << fb); k++) s1 += h1[ax][k];
		h2[ax][0] = s1 >>> fb;
		for (int k = 0; k < (1 << fb); k++) s2 += h2[ax][k];
		return 32'(s2 >>> fb);
	endfunction
	task automatic drive(input imu_abf_pkg::imu_abf_accel_t v);
		#2 raw = v;
		raw_v = 1'b1;
		@(posedge clock);
		#2 raw_v = 1'b0;
		raw = ~v;
		repeat (3) @(posedge clock);
	endtask
	task automatic pair();
		imu_abf_pkg::imu_abf_accel_t a, b, e;
		for (int i = 0; i < 3; i++) begin
			a.axis[i] = ($urandom & 32'h000F_FFFF) - 32'h0008_0000;
			b.axis[i] = ($urandom & 32'h000F_FFFF) - 32'h0008_0000;
			e.axis[i] = model(i, ((sx(a.axis[i]) + sx(b.axis[i])) >>> 1)
				+ sx(bias[i]));
		end
		@(posedge clock);
		drive(a);
		exp_q.push_back(e);
		drive(b);
		repeat (8) @(posedge clock);
	endtask
	task automatic tend(input string n);
		$display("test %s done", n);
	endtask
	always @(negedge clock) begin
		na += (a_req === 1'b1);
		ng += (g_req === 1'b1);
		if (out_v === 1'b1) begin
			e_m = exp_q.pop_front();
			for (int i = 0; i < 3; i++) chk(acc_out.axis[i], e_m.axis[i]);
			@(negedge clock);
			chk(dr, exp_dr);
		end
	end
	initial begin
		#1_500_000;
		errors++;
		print_verdict();
	end
	initial begin
		rst_b = 1'b0;
		raw_v = 1'b0;
		raw = '0;
		tb_sync = 1'b0;
		exp_dr = 1'b1;
		fb = 3'h0;
		h1 = '{default: 0};
		h2 = '{default: 0};
		void'($urandom(26009));
		repeat (6) @(posedge clock);
		#2 rst_b = 1'b1;
		repeat (2) @(posedge clock);
		for (int i = 0; i < 8; i++) begin
			rdchk(ra[i], i == 7 ? 16'h00C1 : 16'h0000);
		end
		tend("reset");
		for (int i = 0; i < 3; i++) begin
			bias[i] = ($urandom & 32'h000F_FFFF) - 32'h0008_0000;
			wr16(ra[2*i], bias[i][15:0]);
			wr16(ra[2*i+1], bias[i][31:16]);
			rdchk(ra[2*i], bias[i][15:0]);
			rdchk(ra[2*i+1], bias[i][31:16]);
		end
		wr(7'h5C, 8'hFA);
		wr(7'h5D, 8'hFF);
		fb = 3'h2;
		rdchk(7'h5C, 16'h0002);
		rdchk(7'h70, 16'h0000);
		tend("registers");
		repeat (6) pair();
		tend("filter");
		wr16(7'h60, 16'h0081);
		chk(pop, 1'b0);
		chk(lin, 1'b1);
		rdchk(7'h60, 16'h0081);
		wr(7'h60, 8'h40);
		chk(lin, 1'b0);
		chk(pop, 1'b1);
		chk(dr, 1'b1);
		exp_dr = 1'b0;
		repeat (2) pair();
		chk(exp_q.size(), 0);
		wr(7'h60, 8'hC1);
		tend("control");
		for (int i = 0; i < 5; i++) begin
			// park on own clock with the new polarity: pin steps ignored
			wr(7'h60, {2'h3, 1'b0, 3'h0, pt[i], 1'b1});
			tb_sync = pt[i];
			wr(7'h60, {2'h3, 1'b0, mt[i], pt[i], 1'b1});
			repeat (2 * HC) @(posedge clock);
			#2 na = 0;
			ng = 0;
			for (int k = 0; k < 8; k++) begin
				if (k < 7 && mt[i] inside {3'h1, 3'h2, 3'h5})
					tb_sync = ~tb_sync;
				repeat (HC) @(posedge clock);
				#2;
			end
			chk(na, at[i]);
			chk(ng, gt[i]);
			chk(s_oe, mt[i] == 3'h3);
		end
		tend("timing");
		print_verdict();
	end
endmodule // imu_abf_config_tb
bind imu_abf_config imu_abf_chk u_chk (.clock, .rst_b, .spi_sclk,
	.spi_cs_b, .spi_dout, .sync_pin_out, .sync_pin_oe, .accel_sample_req,
	.gyro_sample_req, .lin_g_comp_en, .pop_align_en, .accel_out_valid,
	.accel_out);
`default_nettype wire
